//--- core/fbp_check_if.sv
// address check connection between the top and the range checker
`timescale 1ns/1ps
interface fbp_check_if;
    logic [5:0] sel;
    logic [15:0] addr;
    logic hit;
    modport top (output sel, output addr, input hit);
    modport chk (input sel, input addr, output hit);
endinterface

//--- core/fbp_pkg.sv
// types of the flash block protection logic
package fbp_pkg;
    typedef enum logic [1:0] {
        FBP_LOAD_REQ,
        FBP_LOAD_WAIT,
        FBP_RUN
    } fbp_state_t;
endpackage

//--- core/fbp_range_check.sv
// decides whether an address lies in the protected top region
`timescale 1ns/1ps
`include "fbp_regs.svh"
module fbp_range_check
    import fbp_pkg::*;
(
    fbp_check_if.chk chk
);
    logic [16:0] span;
    logic [16:0] lower;
    logic [5:0] steps;

    always_comb begin
        steps = `FBP_SEL_NONE - chk.sel;
        span = 17'(`FBP_STEP_BYTES * {11'h000, steps});
        // clamp at zero
        if (chk.sel <= `FBP_SEL_ALL_MAX) begin
            lower = 17'h00000; // [R5]
        end else begin
            lower = `FBP_TOP_END - span; // [R4] [R7]
        end
        if (chk.sel == `FBP_SEL_NONE) begin
            chk.hit = 1'b0; // [R4]
        end else begin
            chk.hit = {1'b0, chk.addr} >= lower; // [R2]
        end
    end
endmodule

//--- core/fbp_regs.svh
// register offsets, field positions and reset values of the protection block
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH
`define FBP_OFF_CONFIG 4'h0
`define FBP_OFF_STATUS 4'h1
`define FBP_OFF_MASK 4'h2
`define FBP_OFF_NVADDR 4'h3
`define FBP_STAT_VIOL_BIT 5
`define FBP_SEL_NONE 6'h3f
`define FBP_SEL_ALL_MAX 6'h18
`define FBP_STEP_BYTES 17'h00600
`define FBP_TOP_END 17'h10000
`define FBP_NV_ADDR 16'hffbd
`define FBP_SEL_RESET 6'h3f
`define FBP_MASK_RESET 8'h00
`endif

//--- core/fbp_top.sv
// flash block protection: register, reset load, command gate, interrupt
//
// Function
// R1 - six-bit select field, two upper register bits reserved read zero.
// R2 - erase or program inside the protected region is blocked.
// R3 - register loads from nonvolatile configuration byte during reset.
// R4 - region ends at top; 0x3f none; each step down adds 1.5K.
// R5 - select 0x18 down to 0x00 protects the whole 64K space.
// R6 - blocked command ignored, sets status bit 5; write one clears it. The code also clears it on a status read, unless a command is blocked that cycle.
// R7 - lower bound is top minus 0x600 times (0x3f - select), clamped.
`timescale 1ns/1ps
`include "fbp_regs.svh"
module fbp_top
    import fbp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic nv_rd_req,
    output logic [15:0] nv_rd_addr,
    input wire logic nv_rd_valid,
    input wire logic [7:0] nv_rd_data,
    input wire logic cmd_launch,
    input wire logic cmd_modify,
    input wire logic [15:0] cmd_addr,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic prot_ready,
    output logic irq
);
    fbp_state_t state_q;
    logic [5:0] sel_q;
    logic viol_q;
    logic [7:0] mask_q;
    logic [7:0] rdata_q;
    logic [7:0] status;
    logic blocked;
    logic viol_set;
    logic status_rd;

    fbp_check_if chk_if ();

    fbp_range_check u_check (
        .chk(chk_if.chk)
    );

    assign chk_if.sel = sel_q;
    assign chk_if.addr = cmd_addr;

    // ------------------------------------------------------------
    // reset load of the protection register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FBP_LOAD_REQ;
        end else begin
            case (state_q)
                FBP_LOAD_REQ: state_q <= FBP_LOAD_WAIT;
                FBP_LOAD_WAIT: begin
                    if (nv_rd_valid) begin
                        state_q <= FBP_RUN;
                    end
                end
                FBP_RUN: state_q <= FBP_RUN;
                default: state_q <= FBP_LOAD_REQ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= `FBP_SEL_RESET;
        end else if (state_q == FBP_LOAD_WAIT && nv_rd_valid) begin
            sel_q <= nv_rd_data[5:0]; // [R3] [R1]
        end
    end

    assign nv_rd_req = (state_q == FBP_LOAD_REQ);
    assign nv_rd_addr = `FBP_NV_ADDR;
    assign prot_ready = (state_q == FBP_RUN);

    // ------------------------------------------------------------
    // command gate
    // ------------------------------------------------------------
    // modify commands before the load completes are refused as protected
    assign blocked = cmd_modify && (chk_if.hit || !prot_ready); // [R2]
    assign cmd_accept = cmd_launch && !blocked;
    assign cmd_reject = cmd_launch && blocked; // [R6]
    assign viol_set = cmd_reject;

    // ------------------------------------------------------------
    // status, mask and interrupt
    // ------------------------------------------------------------
    assign status_rd = reg_rd && reg_addr == `FBP_OFF_STATUS;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            viol_q <= 1'b0;
        end else if (viol_set) begin
            viol_q <= 1'b1; // [R6]
        end else if (reg_wr && reg_addr == `FBP_OFF_STATUS &&
                     reg_wdata[`FBP_STAT_VIOL_BIT]) begin
            viol_q <= 1'b0; // [R6]
        end else if (status_rd) begin
            viol_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `FBP_MASK_RESET;
        end else if (reg_wr && reg_addr == `FBP_OFF_MASK) begin
            mask_q <= reg_wdata;
        end
    end

    always_comb begin
        status = 8'h00;
        status[`FBP_STAT_VIOL_BIT] = viol_q;
    end

    assign irq = |(status & mask_q);

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `FBP_OFF_CONFIG: rdata_q <= {2'b00, sel_q}; // [R1]
                `FBP_OFF_STATUS: rdata_q <= status;
                `FBP_OFF_MASK: rdata_q <= mask_q;
                `FBP_OFF_NVADDR: rdata_q <= {7'h00, prot_ready};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

//--- tb/fbp_nv_model.sv
// nonvolatile byte store answering the reset load request
`timescale 1ns/1ps
module fbp_nv_model(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic nv_rd_req,
    input wire logic [15:0] nv_rd_addr,
    input wire logic [7:0] cfg,
    output logic nv_rd_valid,
    output logic [7:0] nv_rd_data
);
logic [3:0] cnt_q;
// cfg[7] picks a slow answer; data outside the answer is inverted
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_q <= 4'h0;
        nv_rd_valid <= 1'b0;
        nv_rd_data <= ~cfg;
    end else begin
        nv_rd_valid <= cnt_q == 4'h1;
        nv_rd_data <= cnt_q == 4'h1 && nv_rd_addr == 16'hffbd ? cfg : ~cfg;
        if (nv_rd_req) cnt_q <= cfg[7] ? 4'h6 : 4'h1;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
end
endmodule

//--- tb/fbp_sva.sv
// port assertions of the flash block protection logic
`timescale 1ns/1ps
module fbp_sva(
    input wire logic ref_clk, rst_n, reg_rd, cmd_launch, cmd_modify,
    input wire logic cmd_accept, cmd_reject, prot_ready, nv_rd_req,
    input wire logic nv_rd_valid,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_rdata, nv_rd_data,
    input wire logic [15:0] cmd_addr
);
logic [5:0] sel_q;
logic hit;
always_ff @(posedge ref_clk) if (nv_rd_valid && !prot_ready)
    sel_q <= nv_rd_data[5:0];
assign hit = sel_q <= 6'h18 || (sel_q != 6'h3f &&
    {1'b0, cmd_addr} >= 17'h10000 - 17'h600 * (6'h3f - sel_q));
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
chk_region_gate: assert property (
    cmd_launch && cmd_modify && prot_ready |-> cmd_reject == hit)
    else $error("region gate wrong");
chk_plain_pass: assert property (
    cmd_launch && !cmd_modify && prot_ready |-> cmd_accept && !cmd_reject)
    else $error("plain command blocked");
chk_gate_onehot: assert property (
    cmd_launch |-> cmd_accept ^ cmd_reject) else $error("gate not one-hot");
chk_early_block: assert property (
    cmd_launch && cmd_modify && !prot_ready |-> cmd_reject)
    else $error("early pass");
chk_load_ready: assert property (
    nv_rd_valid && !prot_ready |=> prot_ready) else $error("no ready");
chk_ready_stays: assert property (
    prot_ready |=> prot_ready) else $error("ready dropped");
chk_load_once: assert property (
    nv_rd_req |=> !nv_rd_req) else $error("load request repeated");
chk_reserved_zero: assert property (
    reg_rd && reg_addr == 4'h0 |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits set");
chk_viol_seen: assert property (
    cmd_reject ##1 (reg_rd && reg_addr == 4'h1) |=> reg_rdata[5])
    else $error("violation flag missing");
endmodule
bind fbp_top fbp_sva i_sva(.*);

//--- tb/tb.sv
// self-checking testbench of the flash block protection logic
`timescale 1ns/1ps
module tb;
logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
logic cmd_launch = 0, cmd_modify = 0, nv_rd_req, nv_rd_valid;
logic cmd_accept, cmd_reject, prot_ready, irq, rj, ac;
logic [3:0] reg_addr = 4'h0;
logic [7:0] reg_wdata = 8'h00, reg_rdata, nv_rd_data, cfg = 8'hff, d;
logic [15:0] cmd_addr = 16'h0000, nv_rd_addr;
logic [5:0] sels [6] = '{6'h3f, 6'h00, 6'h18, 6'h19, 6'h20, 6'h3e};
int failures = 0, checks_done = 0;
always #5 ref_clk = ~ref_clk;
fbp_top i_dut(.*);
fbp_nv_model i_nv(.*);
task chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
        failures++;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
endtask
task finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
endtask
task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 0;
endtask
task cmd(input logic m, input logic [15:0] a);
    @(posedge ref_clk);
    cmd_launch <= 1;
    cmd_modify <= m;
    cmd_addr <= a;
    #1 rj = cmd_reject;
    ac = cmd_accept;
    @(posedge ref_clk);
    cmd_launch <= 0;
endtask
// reload from a fresh byte, probing the gate before the load lands
task t_region(input logic [5:0] s);
    int n;
    logic [16:0] lo;
    lo = s <= 6'h18 ? 17'h0 : 17'h10000 - 17'h600 * (6'h3f - s);
    @(posedge ref_clk);
    rst_n <= 0;
    cfg <= {1'b1, s[0], s};
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    cmd(1, 16'h0000);
    chk(rj, 1);
    for (n = 0; n < 20 && prot_ready !== 1'b1; n++) @(posedge ref_clk);
    if (n == 20) begin
        failures++;
        finish_test;
    end
    rd(4'h0);
    chk(d, {2'b00, s});
    if (lo != 0) begin
        cmd(1, lo[15:0] - 16'h1);
        chk(rj, 0);
    end
    if (lo < 17'h10000) begin
        cmd(1, lo[15:0]);
        chk(rj, 1);
        cmd(0, lo[15:0]);
        chk(rj, 0);
        chk(ac, 1);
    end
endtask
task t_irq;
    wr(4'h2, 8'h20);
    cmd(1, 16'hffff);
    #1 chk(irq, 1);
    rd(4'h1);
    chk(d[5], 1);
    chk(irq, 0);
    cmd(1, 16'hffff);
    wr(4'h1, 8'h20);
    #1 chk(irq, 0);
    wr(4'h2, 8'h00);
    cmd(1, 16'hfa00);
    #1 chk(irq, 0);
    rd(4'hf);
    chk(d, 0);
    rd(4'h3);
    chk(d, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk(d, 8'h3e);
endtask
initial begin
    foreach (sels[i]) t_region(sels[i]);
    t_irq;
    finish_test;
end
endmodule
